// ==== core/fcsti_top.sv ====
// transmit stimulus injector and measurement control
`timescale 1ns/1ps
// Summary of operation
// - selected alarm sequence replaces every word while selected; none sends nothing
// - link reset sends K28.5 D9.2 D31.5 D9.2 repeatedly
// - link reset response sends K28.5 D21.1 D31.5 D9.2 repeatedly
// - not operational sends K28.5 D21.2 D31.5 D5.2 repeatedly
// - offline sends K28.5 D21.1 D10.4 D21.2 repeatedly
// - bit error flips one payload bit of a frame
// - symbol error forces an undecodable code group; not in 64b/66b modes
// - receiver ready error sends one R_RDY ordered set per insertion
// - crc error flips one crc bit; not with header-only framing
// - block error corrupts one 64b/66b word; only in 64b/66b modes
// - insertion off means no errors of any type
// - manual insert trigger inserts burst length errors
// - one burst every second in per-second mode
// - one burst every ten seconds in per-ten-second mode
// - rate modes insert bursts at 1E-02 to 1E-07 per transmitted word
// - transmit frequency offset follows the signed deviation setting
// - measurement intervals from the fixed length table or none
// - measurement starts on command or at configured start time
// - measurement ends on stop, at stop time, or after duration
// - full result memory stops measurement or holds at full and logs an event
// - time-to-full estimate recalculated periodically while running
module fcsti_top
  import fcsti_pkg::*;
#(
  parameter int unsigned P_SEC_CYCLES = SEC_CYCLES
) (
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // register port
  input  wire logic [7:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  // transmit stream in
  input  wire logic [31:0] i_tx_data,
  input  wire logic [3:0]  i_tx_k,
  input  wire logic        i_tx_valid,
  input  wire logic        i_tx_payload,
  input  wire logic        i_tx_crc,
  input  wire logic        i_tx_idle,
  // transmit stream out
  output logic      [31:0] o_tx_data,
  output logic      [3:0]  o_tx_k,
  output logic             o_tx_valid,
  output logic             o_tx_sym_err,
  output logic             o_tx_blk_err,
  output logic      [15:0] o_tx_freq_dev,
  // measurement
  input  wire logic [31:0] i_now_sec,
  input  wire logic        i_rec_wr,
  input  wire logic [15:0] i_rec_bytes,
  output logic             o_meas_running,
  output logic             o_interval_tick,
  output logic             o_mem_full_evt
);
  initial begin
    if (P_SEC_CYCLES < 2) $error("fcsti_top second length too short");
  end

  logic [11:0] ctrl_r;
  logic [15:0] burst_r, txdev_r;
  logic [8:0]  mcfg_r;
  logic [31:0] tsta_r, tsto_r, dur_r;
  logic [31:0] sec_cnt_r, rate_cnt_r, fill_r, elap_r, est_r, secb_r;
  logic [3:0]  sec10_r;
  logic [15:0] ivl_cnt_r;
  logic [16:0] pend_r, pend_nxt;
  logic        sec_tick, full_r, est_go;
  fcsti_meas_t ms_r, ms_nxt;
  logic [31:0] os_word, quot;
  logic        div_done;

  logic [2:0] alarm, etype;
  logic [3:0] imode;
  logic       m64, hdr_only, wr_cmd, cmd_ins, cmd_sta, cmd_sto;
  assign alarm    = ctrl_r[2:0];
  assign etype    = ctrl_r[5:3];
  assign imode    = ctrl_r[9:6];
  assign m64      = ctrl_r[10];
  assign hdr_only = ctrl_r[11];
  assign wr_cmd   = i_wr && (i_addr == REG_CMD);
  assign cmd_ins  = wr_cmd && i_wdata[CMD_INSERT];
  assign cmd_sta  = wr_cmd && i_wdata[CMD_START];
  assign cmd_sto  = wr_cmd && i_wdata[CMD_STOP];

  // configuration registers
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ctrl_r  <= CTRL_RST;
      burst_r <= BURST_RST;
      txdev_r <= 16'h0000;
      mcfg_r  <= MCFG_RST;
      tsta_r  <= 32'h0000_0000;
      tsto_r  <= 32'h0000_0000;
      dur_r   <= 32'h0000_0000;
    end else if (i_wr) begin
      case (i_addr)
        REG_CTRL:  ctrl_r  <= i_wdata[11:0];
        REG_BURST: burst_r <= i_wdata[15:0];
        REG_TXDEV: txdev_r <= i_wdata[15:0];
        REG_MCFG:  mcfg_r  <= i_wdata[8:0];
        REG_TSTA:  tsta_r  <= i_wdata;
        REG_TSTO:  tsto_r  <= i_wdata;
        REG_DUR:   dur_r   <= i_wdata;
        default: ;
      endcase
    end
  end
  assign o_tx_freq_dev = txdev_r;

  // read port
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        REG_CTRL:  o_rdata <= {20'h00000, ctrl_r};
        REG_BURST: o_rdata <= {16'h0000, burst_r};
        REG_TXDEV: o_rdata <= {16'h0000, txdev_r};
        REG_MCFG:  o_rdata <= {23'h000000, mcfg_r};
        REG_TSTA:  o_rdata <= tsta_r;
        REG_TSTO:  o_rdata <= tsto_r;
        REG_DUR:   o_rdata <= dur_r;
        REG_STAT:  o_rdata <= {29'h0, full_r, pend_r != 17'h0, ms_r == MS_RUN};
        REG_FILL:  o_rdata <= fill_r;
        REG_EST:   o_rdata <= est_r;
        REG_ELAP:  o_rdata <= elap_r;
        default:   o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  // one-second base tick
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sec_cnt_r <= 32'h0000_0000;
    end else if (sec_cnt_r == 32'(P_SEC_CYCLES - 1)) begin
      sec_cnt_r <= 32'h0000_0000;
    end else begin
      sec_cnt_r <= sec_cnt_r + 32'h1;
    end
  end
  assign sec_tick = (sec_cnt_r == 32'(P_SEC_CYCLES - 1));

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      sec10_r <= 4'h0;
    end else if (sec_tick) begin
      sec10_r <= (sec10_r == BURST10_SEC) ? 4'h0 : sec10_r + 4'h1;
    end
  end

  // insertion engine
  logic rate_mode, rate_hit, type_ok, trig, elig, use_err;
  assign rate_mode = (imode >= IM_RATE2) && (imode <= IM_RATE7);
  assign rate_hit  = rate_mode && i_tx_valid
                     && (rate_cnt_r == fcsti_rate_period(imode) - 32'h1);
  assign type_ok = (etype != ER_NONE)
                   && !(etype == ER_SYM && m64)
                   && !(etype == ER_CRC && hdr_only)
                   && !(etype == ER_BLK && !m64);
  always_comb begin
    case (imode)
      IM_MAN:   trig = cmd_ins;
      IM_SEC:   trig = sec_tick;
      IM_SEC10: trig = sec_tick && (sec10_r == BURST10_SEC);
      default:  trig = rate_hit;
    endcase
  end
  always_comb begin
    case (etype)
      ER_BIT:  elig = i_tx_payload;
      ER_CRC:  elig = i_tx_crc;
      ER_RRDY: elig = i_tx_idle;
      default: elig = 1'b1;
    endcase
  end
  assign use_err = i_tx_valid && elig && type_ok && |pend_r && |imode && (alarm == AL_NONE);

  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || !rate_mode) begin
      rate_cnt_r <= 32'h0000_0000;
    end else if (rate_hit) begin
      rate_cnt_r <= 32'h0000_0000;
    end else if (i_tx_valid) begin
      rate_cnt_r <= rate_cnt_r + 32'h1;
    end
  end

  always_comb begin
    pend_nxt = pend_r - {16'h0, use_err};
    if (trig) begin
      pend_nxt = pend_nxt + {1'b0, burst_r};
    end
    if (imode == IM_OFF || !type_ok) begin
      pend_nxt = 17'h0;
    end
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      pend_r <= 17'h0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  // word substitution stage
  fcsti_oset_rom u_rom (
    .i_sel  ((alarm != AL_NONE) ? alarm : AL_RRDY),
    .o_word (os_word)
  );
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_tx_data    <= 32'h0000_0000;
      o_tx_k       <= 4'h0;
      o_tx_valid   <= 1'b0;
      o_tx_sym_err <= 1'b0;
      o_tx_blk_err <= 1'b0;
    end else begin
      o_tx_valid   <= i_tx_valid;
      o_tx_data    <= i_tx_data;
      o_tx_k       <= i_tx_k;
      o_tx_sym_err <= 1'b0;
      o_tx_blk_err <= 1'b0;
      if (alarm != AL_NONE && alarm != AL_RRDY) begin
        o_tx_data <= os_word;
        o_tx_k    <= OS_K;
      end else if (use_err) begin
        case (etype)
          ER_BIT, ER_CRC: o_tx_data <= i_tx_data ^ 32'h0000_0001;
          ER_RRDY: begin
            o_tx_data <= os_word;
            o_tx_k    <= OS_K;
          end
          ER_SYM:  o_tx_sym_err <= 1'b1;
          ER_BLK:  o_tx_blk_err <= 1'b1;
          default: ;
        endcase
      end
    end
  end

  // measurement state
  logic mem_stop;
  assign mem_stop = full_r && !mcfg_r[8];
  always_comb begin
    ms_nxt = ms_r;
    case (ms_r)
      MS_IDLE:  if (cmd_sta) ms_nxt = mcfg_r[5] ? MS_ARMED : MS_RUN;
      MS_ARMED: begin
        if (cmd_sto) ms_nxt = MS_IDLE;
        else if (i_now_sec >= tsta_r) ms_nxt = MS_RUN;
      end
      MS_RUN: begin
        if (cmd_sto) ms_nxt = MS_IDLE;
        else if (mcfg_r[7:6] == SF_AT && i_now_sec >= tsto_r) ms_nxt = MS_IDLE;
        else if (mcfg_r[7:6] == SF_DUR && elap_r >= dur_r) ms_nxt = MS_IDLE;
        else if (mem_stop) ms_nxt = MS_IDLE;
      end
      default: ms_nxt = MS_IDLE;
    endcase
  end
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      ms_r <= MS_IDLE;
    end else begin
      ms_r <= ms_nxt;
    end
  end
  assign o_meas_running = (ms_r == MS_RUN);

  // elapsed seconds and intervals
  logic [15:0] ivl_len;
  assign ivl_len = fcsti_ivl_sec(mcfg_r[4:0]);
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || ms_r != MS_RUN) begin
      elap_r          <= 32'h0000_0000;
      ivl_cnt_r       <= 16'h0000;
      o_interval_tick <= 1'b0;
    end else begin
      o_interval_tick <= 1'b0;
      if (sec_tick) begin
        elap_r <= elap_r + 32'h1;
        if (ivl_len != 16'h0000 && ivl_cnt_r == ivl_len - 16'h1) begin
          ivl_cnt_r       <= 16'h0000;
          o_interval_tick <= 1'b1;
        end else begin
          ivl_cnt_r <= ivl_cnt_r + 16'h1;
        end
      end
    end
  end

  // result memory fill
  logic [31:0] fill_sum;
  logic        stat_clr;
  assign fill_sum = fill_r + {16'h0000, i_rec_bytes};
  assign stat_clr = i_wr && (i_addr == REG_STAT) && i_wdata[ST_FULL];
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      fill_r         <= 32'h0000_0000;
      full_r         <= 1'b0;
      o_mem_full_evt <= 1'b0;
    end else begin
      o_mem_full_evt <= 1'b0;
      if (cmd_sta && ms_r == MS_IDLE) begin
        fill_r <= 32'h0000_0000;
      end else if (ms_r == MS_RUN && i_rec_wr) begin
        if (fill_sum >= MEM_BYTES) begin
          fill_r <= MEM_BYTES;
          if (fill_r != MEM_BYTES) o_mem_full_evt <= 1'b1;
        end else begin
          fill_r <= fill_sum;
        end
      end
      if (ms_r == MS_RUN && i_rec_wr && fill_sum >= MEM_BYTES && fill_r != MEM_BYTES) begin
        full_r <= 1'b1;
      end else if (stat_clr || (cmd_sta && ms_r == MS_IDLE)) begin
        full_r <= 1'b0;
      end
    end
  end

  // time-to-full estimate
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n || ms_r != MS_RUN) begin
      secb_r <= 32'h0000_0000;
    end else if (sec_tick) begin
      secb_r <= i_rec_wr ? {16'h0000, i_rec_bytes} : 32'h0000_0000;
    end else if (i_rec_wr) begin
      secb_r <= secb_r + {16'h0000, i_rec_bytes};
    end
  end
  assign est_go = o_meas_running && sec_tick && (secb_r != 32'h0);
  fcsti_div #(.W(32)) u_div (
    .i_core_clk (i_core_clk),
    .i_reset_n  (i_reset_n),
    .i_start    (est_go),
    .i_num      (MEM_BYTES - fill_r),
    .i_den      (secb_r),
    .o_done     (div_done),
    .o_quot     (quot)
  );
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      est_r <= 32'hffff_ffff;
    end else if (div_done) begin
      est_r <= quot;
    end
  end

  // checks
  a_alarm_word: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (alarm == AL_LR) && $stable(ctrl_r) |=> (o_tx_data == OS_LR) && (o_tx_k == OS_K))
    else $error("link reset word wrong");
  a_off_clean: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (imode == IM_OFF) && $past(imode == IM_OFF) |-> !use_err)
    else $error("error inserted while off");
  a_sym_64b: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    m64 && $past(m64) |=> !o_tx_sym_err)
    else $error("symbol error in 64b/66b mode");
  a_blk_only64: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    !m64 && $past(!m64) |=> !o_tx_blk_err)
    else $error("block error outside 64b/66b mode");
  a_crc_hdr: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (etype == ER_CRC) && hdr_only |=> (o_tx_data == $past(i_tx_data)) || ($past(alarm) != AL_NONE))
    else $error("crc corrupted with header-only framing");
  a_man_burst: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (imode == IM_MAN) && type_ok && cmd_ins && (pend_r == 17'h0) && !use_err
    && $stable(ctrl_r) |=> pend_r == {1'b0, $past(burst_r)})
    else $error("manual burst count wrong");
  a_stop_cmd: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (ms_r == MS_RUN) && cmd_sto |=> !o_meas_running ##1 !o_meas_running)
    else $error("stop command ignored");
  a_start_now: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    (ms_r == MS_IDLE) && cmd_sta && !mcfg_r[5] |=> o_meas_running)
    else $error("immediate start missed");
  a_full_stop: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    o_mem_full_evt && !mcfg_r[8] && !cmd_sta |=> !o_meas_running)
    else $error("full memory did not stop measurement");
  a_rrdy_word: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
    use_err && (etype == ER_RRDY) |=> (o_tx_data == OS_RRDY) && (o_tx_k == OS_K))
    else $error("receiver ready word wrong");
endmodule // fcsti_top

// ==== include/fcsti_pkg.sv ====
// shared constants for the stimulus injector and measurement control
package fcsti_pkg;
  // timing
  localparam int unsigned CLK_HZ      = 250_000_000;
  localparam int unsigned BASE_PER_S  = 1;
  localparam int unsigned SEC_CYCLES  = CLK_HZ * BASE_PER_S;
  localparam logic [3:0]  BURST10_SEC = 4'h9;
  localparam logic [31:0] MEM_BYTES   = 32'h0400_0000;
  // register offsets
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_BURST = 8'h04;
  localparam logic [7:0] REG_TXDEV = 8'h08;
  localparam logic [7:0] REG_MCFG  = 8'h0c;
  localparam logic [7:0] REG_TSTA  = 8'h10;
  localparam logic [7:0] REG_TSTO  = 8'h14;
  localparam logic [7:0] REG_DUR   = 8'h18;
  localparam logic [7:0] REG_CMD   = 8'h1c;
  localparam logic [7:0] REG_STAT  = 8'h20;
  localparam logic [7:0] REG_FILL  = 8'h24;
  localparam logic [7:0] REG_EST   = 8'h28;
  localparam logic [7:0] REG_ELAP  = 8'h2c;
  // field positions
  localparam int CMD_INSERT = 0;
  localparam int CMD_START  = 1;
  localparam int CMD_STOP   = 2;
  localparam int ST_FULL    = 2;
  // reset values
  localparam logic [11:0] CTRL_RST  = 12'h000;
  localparam logic [15:0] BURST_RST = 16'h0001;
  localparam logic [8:0]  MCFG_RST  = 9'h002;
  // alarm codes
  localparam logic [2:0] AL_NONE = 3'h0;
  localparam logic [2:0] AL_LR   = 3'h1;
  localparam logic [2:0] AL_LRR  = 3'h2;
  localparam logic [2:0] AL_NOS  = 3'h3;
  localparam logic [2:0] AL_OLS  = 3'h4;
  localparam logic [2:0] AL_RRDY = 3'h5;
  // error types
  localparam logic [2:0] ER_NONE = 3'h0;
  localparam logic [2:0] ER_BIT  = 3'h1;
  localparam logic [2:0] ER_SYM  = 3'h2;
  localparam logic [2:0] ER_RRDY = 3'h3;
  localparam logic [2:0] ER_CRC  = 3'h4;
  localparam logic [2:0] ER_BLK  = 3'h5;
  // insertion modes
  localparam logic [3:0] IM_OFF   = 4'h0;
  localparam logic [3:0] IM_MAN   = 4'h1;
  localparam logic [3:0] IM_SEC   = 4'h2;
  localparam logic [3:0] IM_SEC10 = 4'h3;
  localparam logic [3:0] IM_RATE2 = 4'h4;
  localparam logic [3:0] IM_RATE7 = 4'h9;
  // stop functions
  localparam logic [1:0] SF_MAN = 2'h0;
  localparam logic [1:0] SF_AT  = 2'h1;
  localparam logic [1:0] SF_DUR = 2'h2;
  // ordered sets, first character in the top byte
  localparam logic [31:0] OS_LR   = 32'hbc49bf49;
  localparam logic [31:0] OS_LRR  = 32'hbc35bf49;
  localparam logic [31:0] OS_NOS  = 32'hbc55bf45;
  localparam logic [31:0] OS_OLS  = 32'hbc358a55;
  localparam logic [31:0] OS_RRDY = 32'hbc954a4a;
  localparam logic [3:0]  OS_K    = 4'h8;
  localparam logic [9:0]  BAD_CODE = 10'h000;
  typedef enum logic [1:0] {MS_IDLE, MS_ARMED, MS_RUN} fcsti_meas_t;
  // words between bursts in the rate modes
  function automatic logic [31:0] fcsti_rate_period(input logic [3:0] m);
    case (m)
      4'h4: fcsti_rate_period = 32'd100;
      4'h5: fcsti_rate_period = 32'd1000;
      4'h6: fcsti_rate_period = 32'd10000;
      4'h7: fcsti_rate_period = 32'd100000;
      4'h8: fcsti_rate_period = 32'd1000000;
      default: fcsti_rate_period = 32'd10000000;
    endcase
  endfunction
  // interval length in seconds, zero for no intervals
  function automatic logic [15:0] fcsti_ivl_sec(input logic [4:0] c);
    case (c)
      5'h00: fcsti_ivl_sec = 16'd1;
      5'h01: fcsti_ivl_sec = 16'd2;
      5'h02: fcsti_ivl_sec = 16'd5;
      5'h03: fcsti_ivl_sec = 16'd10;
      5'h04: fcsti_ivl_sec = 16'd15;
      5'h05: fcsti_ivl_sec = 16'd30;
      5'h06: fcsti_ivl_sec = 16'd60;
      5'h07: fcsti_ivl_sec = 16'd300;
      5'h08: fcsti_ivl_sec = 16'd600;
      5'h09: fcsti_ivl_sec = 16'd900;
      5'h0a: fcsti_ivl_sec = 16'd1800;
      5'h0b: fcsti_ivl_sec = 16'd3600;
      5'h0c: fcsti_ivl_sec = 16'd7200;
      5'h0d: fcsti_ivl_sec = 16'd14400;
      5'h0e: fcsti_ivl_sec = 16'd21600;
      5'h0f: fcsti_ivl_sec = 16'd43200;
      default: fcsti_ivl_sec = 16'd0;
    endcase
  endfunction
endpackage

// ==== core/fcsti_oset_rom.sv ====
// ordered set lookup for alarms and receiver ready
`timescale 1ns/1ps
module fcsti_oset_rom
  import fcsti_pkg::*;
(
  // select
  input  wire logic [2:0]  i_sel,
  // word
  output logic      [31:0] o_word
);
  always_comb begin
    case (i_sel)
      AL_LR:   o_word = OS_LR;
      AL_LRR:  o_word = OS_LRR;
      AL_NOS:  o_word = OS_NOS;
      AL_OLS:  o_word = OS_OLS;
      AL_RRDY: o_word = OS_RRDY;
      default: o_word = 32'h0000_0000;
    endcase
  end
endmodule // fcsti_oset_rom

// ==== core/fcsti_div.sv ====
// serial restoring divider for the time estimate
`timescale 1ns/1ps
module fcsti_div #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_reset_n,
  // request
  input  wire logic         i_start,
  input  wire logic [W-1:0] i_num,
  input  wire logic [W-1:0] i_den,
  // answer
  output logic              o_done,
  output logic      [W-1:0] o_quot
);
  logic [W-1:0] rem_r, quo_r, den_r;
  logic [5:0]   cnt_r;
  logic [W:0]   trial;
  initial begin
    if (W < 2 || W > 32) $error("fcsti_div width out of range");
  end
  assign trial = {rem_r, quo_r[W-1]} - {1'b0, den_r};
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      rem_r  <= '0;
      quo_r  <= '0;
      den_r  <= '0;
      cnt_r  <= 6'h00;
      o_done <= 1'b0;
      o_quot <= '0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        rem_r <= '0;
        quo_r <= i_num;
        den_r <= i_den;
        cnt_r <= 6'(W);
      end else if (cnt_r != 6'h00) begin
        cnt_r <= cnt_r - 6'h01;
        if (!trial[W]) begin
          rem_r <= trial[W-1:0];
          quo_r <= {quo_r[W-2:0], 1'b1};
        end else begin
          rem_r <= {rem_r[W-2:0], quo_r[W-1]};
          quo_r <= {quo_r[W-2:0], 1'b0};
        end
        if (cnt_r == 6'h01) begin
          o_done <= 1'b1;
          o_quot <= trial[W] ? {quo_r[W-2:0], 1'b0} : {quo_r[W-2:0], 1'b1};
        end
      end
    end
  end
endmodule // fcsti_div

// ==== verification/fcsti_eut_model.sv ====
// far-side equipment model watching the transmit stream
`timescale 1ns/1ps
module fcsti_eut_model
  import fcsti_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_reset_n,
  // received stream
  input  wire logic [31:0] i_rx_data,
  input  wire logic [3:0]  i_rx_k,
  input  wire logic        i_rx_valid,
  input  wire logic        i_rx_sym_err,
  // observations
  output logic      [15:0] o_os_cnt,
  output logic      [15:0] o_sym_cnt
);
  // ordered sets counted only when whole and word aligned
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_os_cnt <= 16'h0000;
    end else if (i_rx_valid && i_rx_k == 4'h8 && i_rx_data[31:24] == 8'hbc) begin
      o_os_cnt <= o_os_cnt + 16'h0001;
    end
  end
  // undecodable code groups seen
  always_ff @(posedge i_core_clk) begin
    if (!i_reset_n) begin
      o_sym_cnt <= 16'h0000;
    end else if (i_rx_valid && i_rx_sym_err) begin
      o_sym_cnt <= o_sym_cnt + 16'h0001;
    end
  end
endmodule // fcsti_eut_model

// ==== verification/testbench.sv ====
// self-checking bench for the stimulus injector
`timescale 1ns/1ps
module testbench
  import fcsti_pkg::*;
;
  logic        i_core_clk, i_reset_n, i_wr, i_rd, i_tx_valid;
  logic        i_tx_payload, i_tx_crc, i_tx_idle, o_tx_valid, o_tx_sym_err;
  logic        o_tx_blk_err, o_meas_running, o_interval_tick, o_mem_full_evt, i_rec_wr;
  logic [7:0]  i_addr;
  logic [31:0] i_wdata, i_tx_data, o_rdata, o_tx_data, d, i_now_sec;
  logic [3:0]  i_tx_k, o_tx_k;
  logic [15:0] o_tx_freq_dev, os_cnt, sym_cnt, i_rec_bytes;
  int          errors, tests_run, seed, cyc, last_tick, full_evts;
  fcsti_top #(.P_SEC_CYCLES(50)) dut (.i_core_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr,
    .i_rd, .o_rdata, .i_tx_data, .i_tx_k, .i_tx_valid, .i_tx_payload, .i_tx_crc, .i_tx_idle,
    .o_tx_data, .o_tx_k, .o_tx_valid, .o_tx_sym_err, .o_tx_blk_err, .o_tx_freq_dev,
    .i_now_sec, .i_rec_wr, .i_rec_bytes, .o_meas_running,
    .o_interval_tick, .o_mem_full_evt);
  fcsti_eut_model eut (.i_core_clk, .i_reset_n, .i_rx_data(o_tx_data), .i_rx_k(o_tx_k),
    .i_rx_valid(o_tx_valid), .i_rx_sym_err(o_tx_sym_err), .o_os_cnt(os_cnt),
    .o_sym_cnt(sym_cnt));
  // data character code from its x.y name
  function automatic logic [7:0] dc(input int x, input int y);
    dc = {y[2:0], x[4:0]};
  endfunction
  function automatic logic [31:0] alarm_exp(input int c);
    case (c)
      1: alarm_exp = {8'hbc, dc(9, 2), dc(31, 5), dc(9, 2)};
      2: alarm_exp = {8'hbc, dc(21, 1), dc(31, 5), dc(9, 2)};
      3: alarm_exp = {8'hbc, dc(21, 2), dc(31, 5), dc(5, 2)};
      default: alarm_exp = {8'hbc, dc(21, 1), dc(10, 4), dc(21, 2)};
    endcase
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_core_clk) #1;
    i_wr <= 1'b0;
    @(posedge i_core_clk) #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_core_clk) #1;
    i_rd <= 1'b0;
    chk(o_rdata, exp, "rdata");
    @(posedge i_core_clk) #1;
  endtask
  // one stream word, flags payload crc idle
  task automatic word(input logic [31:0] v, input logic [3:0] k, input logic [2:0] f);
    i_tx_data <= v;
    i_tx_k <= k;
    i_tx_valid <= 1'b1;
    {i_tx_payload, i_tx_crc, i_tx_idle} <= f;
    @(posedge i_core_clk) #1;
  endtask
  // single insertion, mode 0 pass 1 flip 2 receiver ready
  task automatic err(input logic [31:0] ctrl, input logic [2:0] f, input int m,
                     input logic sy, input logic bl);
    d = $random(seed);
    wr(REG_CTRL, ctrl);
    wr(REG_CMD, 32'h1);
    word(d, 4'h0, f);
    i_tx_valid <= 1'b0;
    chk(o_tx_data, m == 2 ? {8'hbc, dc(21, 4), dc(10, 2), dc(10, 2)} : d ^ (m == 1),
        "err data");
    chk({31'h0, o_tx_sym_err}, {31'h0, sy}, "sym err");
    chk({31'h0, o_tx_blk_err}, {31'h0, bl}, "blk err");
  endtask
  task automatic run_is(input logic v);
    for (int i = 0; i < 4 && o_meas_running !== v; i++) @(posedge i_core_clk) #1;
    chk({31'h0, o_meas_running}, {31'h0, v}, "running");
  endtask
  // flipped bits seen over n zero payload words under one control setting
  task automatic flips(input logic [31:0] ctrl, input int n, input int exp);
    logic [31:0] f;
    f = 32'h0;
    wr(REG_CTRL, ctrl);
    repeat (n) begin
      word(32'h0, 4'h0, 3'h4);
      f = f + {31'h0, o_tx_data[0]};
    end
    i_tx_valid <= 1'b0;
    wr(REG_CTRL, 32'h0);
    chk(f, exp, "flips");
  endtask
  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end
  always @(posedge i_core_clk) begin
    cyc++;
    if (o_interval_tick) begin
      if (last_tick > 0) chk(cyc - last_tick, 32'd50, "interval");
      last_tick = cyc;
    end else if (!o_meas_running) begin
      last_tick = 0;
    end
    if (o_mem_full_evt) full_evts++;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    {i_reset_n, i_wr, i_rd, i_tx_valid, i_tx_payload, i_tx_crc, i_tx_idle, i_rec_wr} = 8'h00;
    {i_addr, i_wdata, i_tx_data, i_tx_k, i_now_sec, i_rec_bytes} = 124'h0;
    {errors, tests_run, cyc, last_tick, full_evts} = 0;
    seed = 95505;
    repeat (16) @(posedge i_core_clk);
    #1 i_reset_n <= 1'b1;
    @(posedge i_core_clk) #1;
    rd(REG_BURST, 32'h1);
    rd(REG_MCFG, 32'h2);
    rd(REG_EST, 32'hffffffff);
    rd(8'hfc, 32'h0);
    for (int c = 1; c <= 4; c++) begin
      wr(REG_CTRL, c);
      word($random(seed), 4'h0, 3'h4);
      word($random(seed), 4'h0, 3'h4);
      chk(o_tx_data, alarm_exp(c), "alarm");
      chk({28'h0, o_tx_k}, 32'h8, "alarm k");
      i_tx_valid <= 1'b0;
    end
    wr(REG_CTRL, 32'h0);
    d = $random(seed);
    word(d, 4'h0, 3'h4);
    chk(o_tx_data, d, "no alarm");
    chk({31'h0, o_tx_valid}, 32'h1, "valid");
    i_tx_valid <= 1'b0;
    wr(REG_BURST, 32'h2);
    wr(REG_CTRL, 32'h48);
    wr(REG_CMD, 32'h1);
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      word(d, 4'h0, 3'h4);
      chk(o_tx_data, d ^ (i < 2), "burst");
    end
    i_tx_valid <= 1'b0;
    wr(REG_BURST, 32'h1);
    err(32'h08, 3'h4, 0, 1'b0, 1'b0);
    err(32'h60, 3'h2, 1, 1'b0, 1'b0);
    err(32'h860, 3'h2, 0, 1'b0, 1'b0);
    err(32'h58, 3'h1, 2, 1'b0, 1'b0);
    err(32'h50, 3'h4, 0, 1'b1, 1'b0);
    err(32'h450, 3'h4, 0, 1'b0, 1'b0);
    err(32'h468, 3'h4, 0, 1'b0, 1'b1);
    err(32'h68, 3'h4, 0, 1'b0, 1'b0);
    flips(32'h88, 200, 4);
    flips(32'hc8, 1000, 2);
    wr(REG_BURST, 32'h3);
    flips(32'h108, 300, 6);
    for (int i = 0; i < 2; i++) begin
      d = i ? 32'h8001 : $random(seed);
      wr(REG_TXDEV, d);
      @(posedge i_core_clk) #1;
      chk({16'h0, o_tx_freq_dev}, {16'h0, d[15:0]}, "freq dev");
    end
    wr(REG_CMD, 32'h2);
    run_is(1'b1);
    rd(REG_STAT, 32'h1);
    wr(REG_CMD, 32'h4);
    run_is(1'b0);
    wr(REG_MCFG, 32'h82);
    wr(REG_DUR, 32'h2);
    wr(REG_CMD, 32'h2);
    run_is(1'b1);
    repeat (40) @(posedge i_core_clk);
    #1 run_is(1'b1);
    repeat (120) @(posedge i_core_clk);
    #1 run_is(1'b0);
    wr(REG_MCFG, 32'h60);
    wr(REG_TSTA, 32'h5);
    wr(REG_TSTO, 32'h7);
    wr(REG_CMD, 32'h2);
    run_is(1'b0);
    i_now_sec <= 32'h5;
    run_is(1'b1);
    i_now_sec <= 32'h7;
    run_is(1'b0);
    wr(REG_MCFG, 32'h100);
    wr(REG_CMD, 32'h2);
    {i_rec_wr, i_rec_bytes} <= 17'h14000;
    @(posedge i_core_clk) #1;
    i_rec_wr <= 1'b0;
    repeat (100) @(posedge i_core_clk);
    #1 rd(REG_EST, 32'hfff);
    rd(REG_FILL, 32'h4000);
    for (int i = 0; i < 2; i++) begin
      {i_rec_wr, i_rec_bytes} <= 17'h1ffff;
      repeat (1040) @(posedge i_core_clk);
      #1 i_rec_wr <= 1'b0;
      chk(full_evts, i + 1, "full events");
      run_is(!i);
      rd(REG_FILL, 32'h0400_0000);
      rd(REG_STAT, i ? 32'h4 : 32'h5);
      wr(REG_CMD, 32'h4);
      wr(REG_MCFG, 32'h0);
      wr(REG_CMD, 32'h2);
    end
    chk({16'h0, os_cnt}, 32'd9, "os count");
    chk({16'h0, sym_cnt}, 32'd1, "sym count");
    end_of_test();
  end
endmodule // testbench
